// >>> common/mmt_pkg.sv
// Package with register map, field positions and shared types of the motor mode timer unit.
package mmt_pkg;

   // Register indices on the plain register port.
   localparam logic [2:0] ADDR_TIMER_CONTROL  = 3'h0;
   localparam logic [2:0] ADDR_CAPTURE_DEBUG  = 3'h1;
   localparam logic [2:0] ADDR_CAPTURED_COUNT = 3'h2;
   localparam logic [2:0] ADDR_COMMUTATION    = 3'h3;
   localparam logic [2:0] ADDR_DETECT_START   = 3'h4;
   localparam logic [2:0] ADDR_OVERFLOW_CMP   = 3'h5;

   // Timer control field positions.
   localparam int TC_TIMER_ENABLE  = 0;
   localparam int TC_DETECT_RESET  = 1;
   localparam int TC_SOFT_RESET    = 2;
   localparam int TC_OVERLOAD_RST  = 3;
   localparam int TC_CH3_RESET     = 4;
   localparam int TC_CLK_SEL_LSB   = 5;

   // Capture/debug control field positions.
   localparam int CD_DETECT_CAPT   = 1;
   localparam int CD_SOFT_CAPT     = 2;
   localparam int CD_OVERLOAD_CAPT = 3;
   localparam int CD_OVERFLOW_FLAG = 5;
   localparam int CD_DEBUG_OUT     = 7;

   // Reset values and counter maximum.
   localparam logic [7:0]  TIMER_CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET         = 16'h0000;
   localparam logic [15:0] COUNT_MAX           = 16'hFFFF;

   // Count clock select codes and their divide ratios.
   localparam logic [2:0] CLK_DIV8   = 3'h0;
   localparam logic [2:0] CLK_DIV16  = 3'h2;
   localparam logic [2:0] CLK_DIV32  = 3'h4;
   localparam logic [2:0] CLK_DIV64  = 3'h6;
   localparam logic [2:0] CLK_DIV128 = 3'h1;
   localparam int PRESCALE_WIDTH = 7;

   // Register port request.
   typedef struct packed {
      logic [2:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } mmt_req_t;

   // Mirror of the three timer interrupt lines.
   typedef struct packed {
      logic overflow_channel;
      logic detect_start;
      logic commutation;
   } mmt_irq_t;

endpackage

// >>> design/mmt_prescaler.sv
// Prescaler that turns the system clock into a count-clock tick for the mode timer.
`timescale 1ns/1ps
`default_nettype none
module mmt_prescaler
   import mmt_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       run,
   input  wire logic [2:0] select,
   output logic            tick
);
   import mmt_pkg::*;

   logic [PRESCALE_WIDTH-1:0] div_q;
   logic [PRESCALE_WIDTH-1:0] mask;

   // Selected ratio as a wrap mask; reserved codes fall back to the slowest rate.
   always_comb begin
      case (select)
         CLK_DIV8:   mask = 7'h07;
         CLK_DIV16:  mask = 7'h0F;
         CLK_DIV32:  mask = 7'h1F;
         CLK_DIV64:  mask = 7'h3F;
         CLK_DIV128: mask = 7'h7F;
         default:    mask = 7'h7F;
      endcase
   end

   // The divider is held clear while stopped so the first tick after start is a full period.
   always_ff @(posedge clock) begin
      if (reset || !run) begin
         div_q <= '0;
         tick  <= 1'b0;
      end else begin
         div_q <= div_q + 7'h01;
         tick  <= ((div_q & mask) == mask);
      end
   end
endmodule
`default_nettype wire

// >>> design/mmt_compare_channel.sv
// One one-shot compare channel of the mode timer.
`timescale 1ns/1ps
`default_nettype none
module mmt_compare_channel
   import mmt_pkg::*;
#(
   parameter bit GREATER_EQUAL = 1'b0
) (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        arm,
   input  wire logic        disarm,
   input  wire logic        counting,
   input  wire logic [15:0] count,
   input  wire logic [15:0] compare,
   output logic             fire
);
   import mmt_pkg::*;

   logic armed_q;
   wire  hit   = GREATER_EQUAL ? (count >= compare) : (count == compare); // [R3] [R4]
   wire  event_now = armed_q && counting && hit;                          // [R7]

   // A write re-arms even with an equal value; firing or a counter reset disarms.
   always_ff @(posedge clock) begin
      if (reset) begin
         armed_q <= 1'b0;
         fire    <= 1'b0;
      end else begin
         fire <= event_now;
         if (arm)
            armed_q <= 1'b1;                                              // [R6]
         else if (event_now || disarm)
            armed_q <= 1'b0;                                              // [R5] [R17]
      end
   end
endmodule
`default_nettype wire

// >>> design/mmt_timer_unit.sv
// Motor mode timer unit: counter, capture, compare channels and register port.
//
// Functional notes
// R1: Up-counting mode timer cleared by position detection.
// R2: Counter holds at maximum and sets readable overflow flag bit 5.
// R3: Commutation compares greater-or-equal; other channels compare exact equality.
// R4: Commutation fires even if compare written after count passed it.
// R5: Each channel fires once per arming; disarms on fire or counter reset.
// R6: Writing compare re-arms even with same value; software rewrites.
// R7: Channels evaluated only while timer enabled and counting.
// R8: Control bit 4 lets channel 3 event reset the counter.
// R9: Control bit 3 lets overload signal reset the counter.
// R10: Writing 1 to control bit 2 resets counter; action bit only.
// R11: Control bit 1 lets position detection reset the counter.
// R12: Capture bit 3 captures count on overload signal.
// R13: Writing 1 to capture bit 2 captures running count.
// R14: Capture bit 1 captures count on each position detection.
// R15: Setting control bit 0 starts the counter.
// R16: Software writes compares before enabling the timer.
// R17: Clearing enable disarms all compare channels.
// R18: Control bits 7 to 5 select the count clock.
// R19: Capture bit 7 drives the interrupt lines onto debug output.
// R20: Select codes 000,010,100,110,001 give divide by 8,16,32,64,128.
// R21: Software changes clock select only while disabled.
// R22: Software avoids read-modify-write on both control registers.
// R23: Capture on a resetting event takes the count before reset.
// R24: Counter increments once per selected tick while enabled only.
`timescale 1ns/1ps
`default_nettype none
module mmt_timer_unit
   import mmt_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire mmt_pkg::mmt_req_t bus_req,
   output logic [15:0]            rdata,
   input  wire logic              position_detect_irq,
   input  wire logic              overload_signal,
   output mmt_pkg::mmt_irq_t      timer_irq,
   output mmt_pkg::mmt_irq_t      debug_irq
);
   import mmt_pkg::*;

   // Register state.
   logic [2:0]  clk_sel_q;
   logic        ch3_reset_enable_q;
   logic        overload_reset_enable_q;
   logic        detect_reset_enable_q;
   logic        timer_enable_q;
   logic        debug_out_enable_q;
   logic        overload_capture_enable_q;
   logic        detect_capture_enable_q;
   logic        count_overflow_flag_q;
   logic [15:0] count_q;
   logic [15:0] captured_count_q;
   logic [15:0] commutation_compare_q;
   logic [15:0] detect_start_compare_q;
   logic [15:0] overflow_compare_q;

   // Synchronised partner inputs; the first stage is read only by the second.
   logic [1:0]  pd_sync_q;
   logic [1:0]  ol_sync_q;
   logic        pd_prev_q;
   logic        ol_prev_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         pd_sync_q <= 2'b00;
         ol_sync_q <= 2'b00;
         pd_prev_q <= 1'b0;
         ol_prev_q <= 1'b0;
      end else begin
         pd_sync_q <= {pd_sync_q[0], position_detect_irq};
         ol_sync_q <= {ol_sync_q[0], overload_signal};
         pd_prev_q <= pd_sync_q[1];
         ol_prev_q <= ol_sync_q[1];
      end
   end

   // Partner events are rising edges of the synchronised levels.
   wire pd_event = pd_sync_q[1] && !pd_prev_q;
   wire ol_event = ol_sync_q[1] && !ol_prev_q;

   // Register decode.
   wire wr_ctrl   = bus_req.wr && (bus_req.addr == ADDR_TIMER_CONTROL);
   wire wr_capdbg = bus_req.wr && (bus_req.addr == ADDR_CAPTURE_DEBUG);
   wire wr_commutation_compare   = bus_req.wr && (bus_req.addr == ADDR_COMMUTATION);
   wire wr_detect_start_compare   = bus_req.wr && (bus_req.addr == ADDR_DETECT_START);
   wire wr_overflow_compare   = bus_req.wr && (bus_req.addr == ADDR_OVERFLOW_CMP);

   // Action bits act on the write cycle and are never stored.
   wire soft_counter_reset = wr_ctrl && bus_req.wdata[TC_SOFT_RESET];      // [R10] [R22]
   wire soft_capture       = wr_capdbg && bus_req.wdata[CD_SOFT_CAPT];     // [R13]

   // Compare channel events; channel 3 is also seen by the counter.
   logic ch3_fire;
   logic ch1_fire;
   logic ch2_fire;

   // Counter reset sources; all but the soft reset are gated by an enable bit.
   wire counter_clear = (pd_event && detect_reset_enable_q)               // [R1] [R11]
                      || (ol_event && overload_reset_enable_q)            // [R9]
                      || (ch3_fire && ch3_reset_enable_q)                 // [R8]
                      || soft_counter_reset;                              // [R10]

   // Capture sources; the captured value is always the pre-reset count.
   wire capture_now = (pd_event && detect_capture_enable_q)               // [R14]
                    || (ol_event && overload_capture_enable_q)            // [R12]
                    || soft_capture;                                      // [R13]

   logic tick;
   wire  at_max   = (count_q == COUNT_MAX);
   wire  counting = timer_enable_q;

   mmt_prescaler u_prescaler (
      .clock  (clock),
      .reset  (reset),
      .run    (timer_enable_q),
      .select (clk_sel_q),                                                // [R18] [R20]
      .tick   (tick)
   );

   // Disarm on counter reset and when the timer is switched off. A level disarm would
   // also drop compares that software loads while stopped, which is the required order.
   wire enable_off  = wr_ctrl && timer_enable_q && !bus_req.wdata[TC_TIMER_ENABLE];
   wire chan_disarm = counter_clear || enable_off;                        // [R5] [R16] [R17]

   mmt_compare_channel #(.GREATER_EQUAL(1'b1)) u_commutation (
      .clock    (clock),
      .reset    (reset),
      .arm      (wr_commutation_compare),
      .disarm   (chan_disarm),
      .counting (counting),
      .count    (count_q),
      .compare  (commutation_compare_q),
      .fire     (ch1_fire)
   );

   mmt_compare_channel #(.GREATER_EQUAL(1'b0)) u_detect_start (
      .clock    (clock),
      .reset    (reset),
      .arm      (wr_detect_start_compare),
      .disarm   (chan_disarm),
      .counting (counting),
      .count    (count_q),
      .compare  (detect_start_compare_q),
      .fire     (ch2_fire)
   );

   mmt_compare_channel #(.GREATER_EQUAL(1'b0)) u_overflow_ch (
      .clock    (clock),
      .reset    (reset),
      .arm      (wr_overflow_compare),
      .disarm   (chan_disarm),
      .counting (counting),
      .count    (count_q),
      .compare  (overflow_compare_q),
      .fire     (ch3_fire)
   );

   // Timer control register.
   always_ff @(posedge clock) begin
      if (reset) begin
         clk_sel_q               <= TIMER_CONTROL_RESET[7:5];
         ch3_reset_enable_q      <= 1'b0;
         overload_reset_enable_q <= 1'b0;
         detect_reset_enable_q   <= 1'b0;
         timer_enable_q          <= 1'b0;
      end else if (wr_ctrl) begin
         clk_sel_q               <= bus_req.wdata[TC_CLK_SEL_LSB +: 3];   // [R18] [R21]
         ch3_reset_enable_q      <= bus_req.wdata[TC_CH3_RESET];
         overload_reset_enable_q <= bus_req.wdata[TC_OVERLOAD_RST];
         detect_reset_enable_q   <= bus_req.wdata[TC_DETECT_RESET];
         timer_enable_q          <= bus_req.wdata[TC_TIMER_ENABLE];       // [R15] [R16]
      end
   end

   // Capture/debug control register; overflow flag is hardware-owned.
   always_ff @(posedge clock) begin
      if (reset) begin
         debug_out_enable_q        <= 1'b0;
         overload_capture_enable_q <= 1'b0;
         detect_capture_enable_q   <= 1'b0;
      end else if (wr_capdbg) begin
         debug_out_enable_q        <= bus_req.wdata[CD_DEBUG_OUT];        // [R19]
         overload_capture_enable_q <= bus_req.wdata[CD_OVERLOAD_CAPT];
         detect_capture_enable_q   <= bus_req.wdata[CD_DETECT_CAPT];
      end
   end

   // Compare registers; software must load them before enabling.
   always_ff @(posedge clock) begin
      if (reset) begin
         commutation_compare_q  <= COUNT_RESET;
         detect_start_compare_q <= COUNT_RESET;
         overflow_compare_q     <= COUNT_RESET;
      end else begin
         if (wr_commutation_compare)
            commutation_compare_q  <= bus_req.wdata;
         if (wr_detect_start_compare)
            detect_start_compare_q <= bus_req.wdata;
         if (wr_overflow_compare)
            overflow_compare_q     <= bus_req.wdata;
      end
   end

   // Mode timer: clear wins, then saturating count on each tick while enabled.
   always_ff @(posedge clock) begin
      if (reset)
         count_q <= COUNT_RESET;
      else if (counter_clear)
         count_q <= COUNT_RESET;                                          // [R1]
      else if (timer_enable_q && tick && !at_max)
         count_q <= count_q + 16'h0001;                                   // [R24] [R2]
   end

   // Overflow flag is sticky until the counter is reset; reaching the top again re-sets it.
   always_ff @(posedge clock) begin
      if (reset)
         count_overflow_flag_q <= 1'b0;
      else if (timer_enable_q && tick && (count_q == (COUNT_MAX - 16'h0001)) && !counter_clear)
         count_overflow_flag_q <= 1'b1;                                   // [R2]
      else if (counter_clear)
         count_overflow_flag_q <= 1'b0;
   end

   // Capture reads count_q in the same cycle a reset clears it, so it sees the old value.
   always_ff @(posedge clock) begin
      if (reset)
         captured_count_q <= COUNT_RESET;
      else if (capture_now)
         captured_count_q <= count_q;                                     // [R23]
   end

   // Read multiplexer; action bits and unused bits read as zero, unmapped reads give zero.
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      case (bus_req.addr)
         ADDR_TIMER_CONTROL: begin
            rd_mux[TC_CLK_SEL_LSB +: 3] = clk_sel_q;
            rd_mux[TC_CH3_RESET]        = ch3_reset_enable_q;
            rd_mux[TC_OVERLOAD_RST]     = overload_reset_enable_q;
            rd_mux[TC_DETECT_RESET]     = detect_reset_enable_q;
            rd_mux[TC_TIMER_ENABLE]     = timer_enable_q;
         end
         ADDR_CAPTURE_DEBUG: begin
            rd_mux[CD_DEBUG_OUT]     = debug_out_enable_q;
            rd_mux[CD_OVERFLOW_FLAG] = count_overflow_flag_q;             // [R2]
            rd_mux[CD_OVERLOAD_CAPT] = overload_capture_enable_q;
            rd_mux[CD_DETECT_CAPT]   = detect_capture_enable_q;
         end
         ADDR_CAPTURED_COUNT: rd_mux = captured_count_q;
         ADDR_COMMUTATION:    rd_mux = commutation_compare_q;
         ADDR_DETECT_START:   rd_mux = detect_start_compare_q;
         ADDR_OVERFLOW_CMP:   rd_mux = overflow_compare_q;
         default:             rd_mux = 16'h0000;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clock) begin
      if (reset)
         rdata <= 16'h0000;
      else if (bus_req.rd)
         rdata <= rd_mux;
      else
         rdata <= 16'h0000;
   end

   // Interrupt pulses and their debug mirror, registered so both come from flip-flops.
   always_ff @(posedge clock) begin
      if (reset) begin
         timer_irq <= '0;
         debug_irq <= '0;
      end else begin
         timer_irq <= {ch3_fire, ch2_fire, ch1_fire};
         debug_irq <= debug_out_enable_q ? {ch3_fire, ch2_fire, ch1_fire} : 3'b000; // [R19]
      end
   end
endmodule
`default_nettype wire

// >>> test/mmt_timer_unit_chk.sv
// Concurrent checks on the ports of the motor mode timer unit.
`timescale 1ns/1ps
`default_nettype none
module mmt_timer_unit_chk
   import mmt_pkg::*;
(
   input wire logic              clock,
   input wire logic              reset,
   input wire mmt_pkg::mmt_req_t bus_req,
   input wire logic [15:0]       rdata,
   input wire logic              position_detect_irq,
   input wire logic              overload_signal,
   input wire mmt_pkg::mmt_irq_t timer_irq,
   input wire mmt_pkg::mmt_irq_t debug_irq
);
   logic [7:0]  tc_q;
   logic [7:0]  cd_q;
   logic [15:0] cmp_q [3];
   logic [2:0]  wrote_q;
   // Decodes of the register port, kept as wires so the properties can sample them.
   wire logic       wr_tc   = bus_req.wr && bus_req.addr == ADDR_TIMER_CONTROL;
   wire logic       wr_cd   = bus_req.wr && bus_req.addr == ADDR_CAPTURE_DEBUG;
   wire logic       rd_tc   = bus_req.rd && bus_req.addr == ADDR_TIMER_CONTROL;
   wire logic       rd_cd   = bus_req.rd && bus_req.addr == ADDR_CAPTURE_DEBUG;
   wire logic       rd_cmp  = bus_req.rd &&
                              bus_req.addr inside {ADDR_COMMUTATION, ADDR_DETECT_START, ADDR_OVERFLOW_CMP};
   wire logic [2:0] wr_cmp  = {3{bus_req.wr}} & {bus_req.addr == ADDR_OVERFLOW_CMP,
                               bus_req.addr == ADDR_DETECT_START, bus_req.addr == ADDR_COMMUTATION};
   wire logic [15:0] cmp_sel = (bus_req.addr == ADDR_COMMUTATION) ? cmp_q[0] :
                               (bus_req.addr == ADDR_DETECT_START) ? cmp_q[1] : cmp_q[2];
   wire logic       en_w    = tc_q[0];
   wire logic       dbg_w   = cd_q[7];
   // Shadow of what software wrote; a channel counts as armed from its compare write until it fires or the timer is switched off.
   // Soft and event resets also disarm, so this is only a necessary condition for a fire.
   always_ff @(posedge clock) begin
      if (reset) begin
         tc_q <= 8'h00;
         cd_q <= 8'h00;
         wrote_q <= 3'h0;
         cmp_q <= '{16'h0000, 16'h0000, 16'h0000};
      end else begin
         if (wr_tc) tc_q <= bus_req.wdata[7:0];
         if (wr_cd) cd_q <= bus_req.wdata[7:0];
         for (int k = 0; k < 3; k++) if (wr_cmp[k]) cmp_q[k] <= bus_req.wdata;
         wrote_q <= (wrote_q & ~timer_irq & {3{!(wr_tc && !bus_req.wdata[0] && tc_q[0])}}) | wr_cmp;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   property p_tc_read;
      $past(rd_tc) |-> rdata == {8'h00, $past(tc_q) & 8'hFB};
   endproperty
   a_tc_read: assert property (p_tc_read) else $error("timer control read back wrong");
   property p_cd_read;
      $past(rd_cd) |-> (rdata & 16'h008E) == {8'h00, $past(cd_q) & 8'h8A};
   endproperty
   a_cd_read: assert property (p_cd_read) else $error("capture control read back wrong");
   property p_cmp_read;
      $past(rd_cmp) |-> rdata == $past(cmp_sel);
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("compare read back wrong");
   property p_pulse;
      timer_irq != 3'h0 |=> (timer_irq & $past(timer_irq)) == 3'h0;
   endproperty
   a_pulse: assert property (p_pulse) else $error("interrupt longer than one cycle");
   property p_armed;
      (timer_irq & ~wrote_q) == 3'h0;
   endproperty
   a_armed: assert property (p_armed) else $error("interrupt without arming write");
   property p_idle;
      !en_w && !$past(en_w) && !$past(en_w, 2) && !$past(en_w, 3) |-> timer_irq == 3'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("interrupt while timer disabled");
   property p_dbg_off;
      !dbg_w && !$past(dbg_w) && !$past(dbg_w, 2) |-> debug_irq == 3'h0;
   endproperty
   a_dbg_off: assert property (p_dbg_off) else $error("debug output while disabled");
   property p_dbg_on;
      dbg_w && $past(dbg_w) && timer_irq != 3'h0 |-> ##[0:1] debug_irq != 3'h0;
   endproperty
   a_dbg_on: assert property (p_dbg_on) else $error("debug output missed interrupt");
endmodule
`default_nettype wire

// >>> test/mmt_partner.sv
// Behavioural model of the position detector and overload protection feeding the timer unit.
`timescale 1ns/1ps
`default_nettype none
module mmt_partner (
   input  wire logic clock,
   output logic      position_detect_irq,
   output logic      overload_signal
);
   // Both lines idle low; one rising edge is one event.
   initial begin
      position_detect_irq = 1'b0;
      overload_signal = 1'b0;
   end
   // High then low for three cycles each, so the two-stage synchroniser sees exactly one rise.
   task automatic pulse(input logic overload);
      @(posedge clock);
      if (overload) overload_signal <= 1'b1;
      else position_detect_irq <= 1'b1;
      repeat (3) @(posedge clock);
      overload_signal <= 1'b0;
      position_detect_irq <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// >>> test/mmt_timer_unit_test.sv
// Self-checking testbench of the motor mode timer unit with its partner model.
`timescale 1ns/1ps
`default_nettype none
module mmt_timer_unit_test;
   import mmt_pkg::*;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   mmt_req_t    bus_req = '0;
   logic [15:0] rdata;
   logic        position_detect_irq;
   logic        overload_signal;
   mmt_irq_t    timer_irq;
   mmt_irq_t    debug_irq;
   logic        rd_seen = 1'b0;
   logic [31:0] exp_q [$];
   logic [31:0] e;
   logic [15:0] v;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          seed = 32'h2472;
   int          irq_n [3] = '{0, 0, 0};
   logic [2:0]  codes [5] = '{CLK_DIV8, CLK_DIV16, CLK_DIV32, CLK_DIV64, CLK_DIV128};
   int          divs [5] = '{8, 16, 32, 64, 128};
   always #10 clock = ~clock;
   mmt_timer_unit u_mmt_timer_unit (.clock(clock), .reset(reset), .bus_req(bus_req), .rdata(rdata),
      .position_detect_irq(position_detect_irq), .overload_signal(overload_signal),
      .timer_irq(timer_irq), .debug_irq(debug_irq));
   mmt_partner u_mmt_partner (.clock(clock), .position_detect_irq(position_detect_irq),
      .overload_signal(overload_signal));
   // Watcher: counts interrupt pulses and checks each read answer against the oldest noted range.
   always @(posedge clock) begin
      rd_seen <= bus_req.rd;
      for (int i = 0; i < 3; i++) if (timer_irq[i] === 1'b1) irq_n[i]++;
      if (rd_seen === 1'b1) begin
         e = exp_q.pop_front();
         cmp_count++;
         if (((rdata >= e[31:16]) && (rdata <= e[15:0])) !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: read %h outside %h..%h", $time, rdata, e[31:16], e[15:0]);
         end
      end
   end
   // Whole-register writes only; action bits read back as zero, so no read-modify-write.
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] lo, input logic [15:0] hi);
      exp_q.push_back({lo, hi});
      @(posedge clock);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clock);
      bus_req.rd <= 1'b0;
   endtask
   // Counts are known only to within the prescaler phase, hence the window of three ticks either side.
   task automatic rn(input logic [2:0] a, input int x);
      rd(a, 16'((x < 3) ? 0 : x - 3), 16'(x + 3));
   endtask
   task automatic capt(input logic [7:0] cd, input int x);
      wr(ADDR_CAPTURE_DEBUG, {8'h00, cd | 8'h04});
      rn(ADDR_CAPTURED_COUNT, x);
   endtask
   task automatic chk(input int ch, input int n);
      cmp_count++;
      if (irq_n[ch] != n) begin
         n_mismatch++;
         $display("mismatch at %0t: channel %0d fired %0d times", $time, ch, irq_n[ch]);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard.
   initial begin
      repeat (100000) @(posedge clock);
      n_mismatch++;
      $display("mismatch at %0t: run did not finish", $time);
      stop_test();
   end
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      for (int a = 0; a < 7; a++) rd(3'(a), 16'h0000, 16'h0000);
      for (int a = 3; a < 6; a++) begin
         v = 16'($random(seed));
         wr(3'(a), v);
         rd(3'(a), v, v);
      end
      wr(ADDR_TIMER_CONTROL, 16'h001E);
      rd(ADDR_TIMER_CONTROL, 16'h001A, 16'h001A);
      wr(ADDR_CAPTURE_DEBUG, 16'h008E);
      rd(ADDR_CAPTURE_DEBUG, 16'h008A, 16'h008A);
      // Each divide code: select while stopped, start with a soft reset, capture after 1281 cycles.
      foreach (codes[i]) begin
         wr(ADDR_TIMER_CONTROL, {8'h00, codes[i], 5'h00});
         wr(ADDR_TIMER_CONTROL, {8'h00, codes[i], 5'h05});
         repeat (1279) @(posedge clock);
         capt(8'h00, 1281 / divs[i]);
      end
      wr(ADDR_CAPTURE_DEBUG, 16'h0080);
      wr(ADDR_TIMER_CONTROL, 16'h0005);
      repeat (400) @(posedge clock);
      wr(ADDR_COMMUTATION, 16'h000A);
      repeat (10) @(posedge clock);
      chk(0, 1);
      repeat (200) @(posedge clock);
      chk(0, 1);
      wr(ADDR_COMMUTATION, 16'h000A);
      repeat (10) @(posedge clock);
      chk(0, 2);
      wr(ADDR_TIMER_CONTROL, 16'h0005);
      repeat (400) @(posedge clock);
      wr(ADDR_DETECT_START, 16'h000A);
      repeat (100) @(posedge clock);
      chk(1, 0);
      wr(ADDR_DETECT_START, 16'h0046);
      repeat (300) @(posedge clock);
      chk(1, 1);
      wr(ADDR_TIMER_CONTROL, 16'h0015);
      wr(ADDR_OVERFLOW_CMP, 16'h001E);
      repeat (397) @(posedge clock);
      capt(8'h00, 20);
      repeat (300) @(posedge clock);
      chk(2, 1);
      wr(ADDR_TIMER_CONTROL, 16'h0007);
      wr(ADDR_CAPTURE_DEBUG, 16'h0002);
      repeat (400) @(posedge clock);
      u_mmt_partner.pulse(1'b0);
      rn(ADDR_CAPTURED_COUNT, 51);
      repeat (160) @(posedge clock);
      u_mmt_partner.pulse(1'b0);
      rn(ADDR_CAPTURED_COUNT, 21);
      wr(ADDR_TIMER_CONTROL, 16'h000D);
      wr(ADDR_CAPTURE_DEBUG, 16'h0008);
      repeat (240) @(posedge clock);
      u_mmt_partner.pulse(1'b1);
      rn(ADDR_CAPTURED_COUNT, 31);
      repeat (160) @(posedge clock);
      capt(8'h08, 21);
      wr(ADDR_TIMER_CONTROL, 16'h0005);
      wr(ADDR_COMMUTATION, 16'h0028);
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      repeat (400) @(posedge clock);
      capt(8'h00, 0);
      wr(ADDR_TIMER_CONTROL, 16'h0001);
      repeat (600) @(posedge clock);
      chk(0, 2);
      // Load a compare while stopped, then start: the channel must survive until enabled.
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      wr(ADDR_COMMUTATION, 16'h000A);
      repeat (20) @(posedge clock);
      chk(0, 2);
      wr(ADDR_TIMER_CONTROL, 16'h0001);
      repeat (10) @(posedge clock);
      chk(0, 3);
      repeat (3) @(posedge clock);
      stop_test();
   end
endmodule
bind mmt_timer_unit mmt_timer_unit_chk u_mmt_timer_unit_chk (.clock(clock), .reset(reset), .bus_req(bus_req),
   .rdata(rdata), .position_detect_irq(position_detect_irq), .overload_signal(overload_signal),
   .timer_irq(timer_irq), .debug_irq(debug_irq));
`default_nettype wire
